// ===== include/disk_dma_pkg.sv
// constants and carriers for the dma write command block
package disk_dma_pkg;
    // task-file register offsets
    localparam logic [2:0] TF_DATA     = 3'h0;
    localparam logic [2:0] TF_FEAT_ERR = 3'h1;
    localparam logic [2:0] TF_COUNT    = 3'h2;
    localparam logic [2:0] TF_SECTOR   = 3'h3;
    localparam logic [2:0] TF_CYL_LO   = 3'h4;
    localparam logic [2:0] TF_CYL_HI   = 3'h5;
    localparam logic [2:0] TF_DEV_HEAD = 3'h6;
    localparam logic [2:0] TF_CMD_STAT = 3'h7;
    // command bytes
    localparam logic [7:0] CMD_BUF_WRITE_DMA   = 8'heb;
    localparam logic [7:0] CMD_MEDIA_WRITE_DMA = 8'hca;
    // error_report, status_report and device/head bit positions
    localparam int ERR_UNC_BIT   = 6;
    localparam int ERR_ABORT_BIT = 2;
    localparam int STAT_BUSY_BIT = 7;
    localparam int STAT_RDY_BIT  = 6;
    localparam int STAT_DSC_BIT  = 4;
    localparam int STAT_ERR_BIT  = 0;
    localparam int DEV_LBA_BIT   = 6;
    // reset values and the zero sector count
    localparam logic [7:0] TF_RESET    = 8'h00;
    localparam logic [7:0] ERR_RESET   = 8'h00;
    localparam logic [7:0] COUNT_ZERO  = 8'h00;
    // data path sizing
    localparam int WORD_W       = 16;
    localparam int FIFO_DEPTH   = 4;
    localparam int SECTOR_WORDS = 256;
    localparam logic [8:0] SECTOR_WORDS_CNT = 9'd256;
    localparam logic [8:0] MAX_SECTORS      = 9'd256;
    // sector-mode geometry used when stepping to the next sector
    localparam logic [7:0] GEOM_SECTORS  = 8'd63;
    localparam logic [3:0] GEOM_LAST_HEAD = 4'd15;

    // one task-file access from the host adapter
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } tf_req_t;

    // one word toward the media write path
    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic              last;
    } media_word_t;
endpackage

// ===== hw/disk_dma_write.sv
// dma write command handling: word fifo, sector buffer and command engine
`timescale 1ns/1ps
`default_nettype none

// small word fifo with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      fill_q;
    logic             push;
    logic             pop;

    // honest full and empty from the fill level
    assign in_ready  = (fill_q != (AW+1)'(DEPTH));
    assign out_valid = (fill_q != '0);
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            fill_q   <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // word_fifo

module disk_dma_write
    import disk_dma_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire tf_req_t           tf_req,
    output logic        [7:0]      tf_rdata_q,
    output logic                   intrq_q,
    output logic                   dmarq,
    input  wire logic              dma_wr,
    input  wire logic [WORD_W-1:0] dma_data,
    output logic                   med_valid,
    input  wire logic              med_ready,
    output media_word_t            med_word,
    input  wire logic              med_done,
    input  wire logic              med_unc,
    input  wire logic [7:0]        buf_rd_addr,
    output logic [WORD_W-1:0]      buf_rd_data_q
);
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_MWAIT, ST_FIN} state_t;

    state_t            state_q;
    logic              cmd_buf_q;
    logic              abort_q;
    logic              fail_q;
    logic [8:0]        in_cnt_q;
    logic [8:0]        out_cnt_q;
    logic [8:0]        remain_q;
    logic [7:0]        err_q;
    logic [7:0]        feat_q;
    logic [7:0]        count_q;
    logic [7:0]        sector_q;
    logic [7:0]        cyl_lo_q;
    logic [7:0]        cyl_hi_q;
    logic [7:0]        dev_head_q;
    logic [WORD_W-1:0] sbuf_q [SECTOR_WORDS];
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic              host_take;
    logic              drain;
    logic              last_drain;
    logic              cmd_wr;
    logic              is_buf_cmd;
    logic              is_med_cmd;
    logic              sect_ok;
    logic              busy;
    logic [7:0]        status;
    logic [27:0]       next_addr;

    assign busy    = (state_q != ST_IDLE);
    assign cmd_wr  = tf_req.wr && (tf_req.addr == TF_CMD_STAT) && !busy;
    assign is_buf_cmd = (tf_req.wdata == CMD_BUF_WRITE_DMA);
    assign is_med_cmd = (tf_req.wdata[7:1] == CMD_MEDIA_WRITE_DMA[7:1]);
    assign sect_ok = (state_q == ST_MWAIT) && med_done && !med_unc;

    // request words only for the current sector and only while the fifo has room
    assign dmarq     = (state_q == ST_XFER) && (in_cnt_q != SECTOR_WORDS_CNT) && fifo_in_ready;
    assign host_take = dmarq && dma_wr;
    assign fifo_out_ready = (state_q == ST_XFER) && (cmd_buf_q || med_ready);
    assign drain      = fifo_out_valid && fifo_out_ready;
    assign last_drain = drain && (out_cnt_q == SECTOR_WORDS_CNT - 9'd1);
    assign med_valid  = fifo_out_valid && (state_q == ST_XFER) && !cmd_buf_q;
    assign med_word   = '{data: fifo_out_data, last: (out_cnt_q == SECTOR_WORDS_CNT - 9'd1)};

    // 16-bit words pass the fifo on their way in
    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (host_take),
        .in_ready  (fifo_in_ready),
        .in_data   (dma_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // step to the next sector address in block or sector mode
    always_comb
    begin
        next_addr = {dev_head_q[3:0], cyl_hi_q, cyl_lo_q, sector_q};
        if (dev_head_q[DEV_LBA_BIT])
        begin
            next_addr = next_addr + 28'h0000001;
        end
        else if (sector_q >= GEOM_SECTORS)
        begin
            next_addr[7:0] = 8'h01;
            if (dev_head_q[3:0] == GEOM_LAST_HEAD)
            begin
                next_addr[27:24] = 4'h0;
                next_addr[23:8]  = {cyl_hi_q, cyl_lo_q} + 16'h0001;
            end
            else
            begin
                next_addr[27:24] = dev_head_q[3:0] + 4'h1;
            end
        end
        else
        begin
            next_addr[7:0] = sector_q + 8'h01;
        end
    end

    // command engine
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q   <= ST_IDLE;
            cmd_buf_q <= 1'b0;
            abort_q   <= 1'b0;
            fail_q    <= 1'b0;
            remain_q  <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cmd_wr)
                    begin
                        fail_q    <= 1'b0;
                        cmd_buf_q <= is_buf_cmd;
                        abort_q   <= !(is_buf_cmd || is_med_cmd);
                        remain_q  <= (count_q == COUNT_ZERO) ? MAX_SECTORS
                                                             : {1'b0, count_q};
                        if (is_buf_cmd)
                        begin
                            remain_q <= 9'd1;
                        end
                        state_q <= (is_buf_cmd || is_med_cmd) ? ST_XFER : ST_FIN;
                    end
                end
                ST_XFER:
                begin
                    if (last_drain)
                    begin
                        state_q <= cmd_buf_q ? ST_FIN : ST_MWAIT;
                    end
                end
                ST_MWAIT:
                begin
                    if (med_done && med_unc)
                    begin
                        fail_q  <= 1'b1;
                        state_q <= ST_FIN;
                    end
                    else if (med_done)
                    begin
                        remain_q <= remain_q - 9'd1;
                        state_q  <= (remain_q == 9'd1) ? ST_FIN : ST_XFER;
                    end
                end
                ST_FIN:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // per-sector word counters on both sides of the fifo
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            in_cnt_q  <= '0;
            out_cnt_q <= '0;
        end
        else if (cmd_wr || sect_ok)
        begin
            in_cnt_q  <= '0;
            out_cnt_q <= '0;
        end
        else
        begin
            in_cnt_q  <= in_cnt_q + 9'(host_take);
            out_cnt_q <= out_cnt_q + 9'(drain);
        end
    end

    // sector buffer: written by the buffer command, read back on its own port
    always_ff @(posedge core_clk)
    begin
        if (drain && cmd_buf_q)
        begin
            sbuf_q[out_cnt_q[7:0]] <= fifo_out_data;
        end
        buf_rd_data_q <= sbuf_q[buf_rd_addr];
    end

    // task-file registers: host writes while idle, ending values at completion
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            feat_q     <= TF_RESET;
            count_q    <= TF_RESET;
            sector_q   <= TF_RESET;
            cyl_lo_q   <= TF_RESET;
            cyl_hi_q   <= TF_RESET;
            dev_head_q <= TF_RESET;
            err_q      <= ERR_RESET;
        end
        else
        begin
            if (tf_req.wr && !busy)
            begin
                case (tf_req.addr)
                    TF_FEAT_ERR: feat_q     <= tf_req.wdata;
                    TF_COUNT:    count_q    <= tf_req.wdata;
                    TF_SECTOR:   sector_q   <= tf_req.wdata;
                    TF_CYL_LO:   cyl_lo_q   <= tf_req.wdata;
                    TF_CYL_HI:   cyl_hi_q   <= tf_req.wdata;
                    TF_DEV_HEAD: dev_head_q <= tf_req.wdata;
                    TF_CMD_STAT: err_q      <= ERR_RESET;
                    default:     err_q      <= err_q;
                endcase
            end
            // address advances only when another sector follows
            if (sect_ok && remain_q != 9'd1)
            begin
                sector_q        <= next_addr[7:0];
                {cyl_hi_q, cyl_lo_q} <= next_addr[23:8];
                dev_head_q[3:0] <= next_addr[27:24];
            end
            if (state_q == ST_FIN)
            begin
                if (!cmd_buf_q && !abort_q)
                begin
                    count_q <= fail_q ? remain_q[7:0] : COUNT_ZERO;
                end
                err_q <= ERR_RESET;
                err_q[ERR_ABORT_BIT] <= abort_q;
                err_q[ERR_UNC_BIT]   <= fail_q;
            end
        end
    end

    // status_report view
    always_comb
    begin
        status                = 8'h00;
        status[STAT_BUSY_BIT] = busy;
        status[STAT_RDY_BIT]  = 1'b1;
        status[STAT_DSC_BIT]  = 1'b1;
        status[STAT_ERR_BIT]  = (err_q != ERR_RESET);
    end

    // registered read data for the task file
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tf_rdata_q <= 8'h00;
        end
        else if (tf_req.rd)
        begin
            case (tf_req.addr)
                TF_FEAT_ERR: tf_rdata_q <= err_q;
                TF_COUNT:    tf_rdata_q <= count_q;
                TF_SECTOR:   tf_rdata_q <= sector_q;
                TF_CYL_LO:   tf_rdata_q <= cyl_lo_q;
                TF_CYL_HI:   tf_rdata_q <= cyl_hi_q;
                TF_DEV_HEAD: tf_rdata_q <= dev_head_q;
                TF_CMD_STAT: tf_rdata_q <= status;
                default:     tf_rdata_q <= 8'h00;
            endcase
        end
    end

    // interrupt raised once as status settles; cleared by status read or new command
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            intrq_q <= 1'b0;
        end
        else if (state_q == ST_FIN)
        begin
            intrq_q <= 1'b1;
        end
        else if ((tf_req.rd || tf_req.wr) && tf_req.addr == TF_CMD_STAT)
        begin
            intrq_q <= 1'b0;
        end
    end

    // helper state for the checks below
    logic       irq_seen_q;
    logic [8:0] buf_words_q;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_seen_q  <= 1'b0;
            buf_words_q <= '0;
        end
        else
        begin
            irq_seen_q  <= cmd_wr ? 1'b0 : (irq_seen_q || state_q == ST_FIN);
            buf_words_q <= cmd_wr ? 9'd0 : buf_words_q + 9'(drain && cmd_buf_q);
        end
    end

    AST_DMARQ_IN_XFER: assert property (@(posedge core_clk) disable iff (!rst_b)
        dmarq |-> state_q == ST_XFER && in_cnt_q < SECTOR_WORDS_CNT)
        else $error("dmarq outside data phase");
    AST_ONE_IRQ: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(intrq_q) |-> !$past(irq_seen_q))
        else $error("second interrupt for one command");
    AST_IRQ_AFTER_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(intrq_q) |-> !busy && $past(state_q == ST_FIN))
        else $error("interrupt before ending status");
    AST_ZERO_IS_256: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && is_med_cmd && count_q == COUNT_ZERO |=> remain_q == MAX_SECTORS)
        else $error("zero count not taken as 256");
    AST_UNC_STOPS: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ST_MWAIT && med_done && med_unc |=> state_q == ST_FIN ##1
        !med_valid && err_q[ERR_UNC_BIT])
        else $error("write continued after uncorrectable error");
    AST_BUF_ONE_SECTOR: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ST_FIN && cmd_buf_q |-> buf_words_q == SECTOR_WORDS_CNT)
        else $error("buffer write did not move one sector");
    AST_COUNT_RESIDUE: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_q == ST_FIN && !cmd_buf_q && !abort_q && !fail_q |=> count_q == COUNT_ZERO)
        else $error("count not zero after clean write");
    AST_ABORT_ERR: assert property (@(posedge core_clk) disable iff (!rst_b)
        cmd_wr && !is_buf_cmd && !is_med_cmd |=> ##1 !busy && status[STAT_ERR_BIT]
        && err_q[ERR_ABORT_BIT] && intrq_q)
        else $error("rejected command without abort status");
endmodule // disk_dma_write
`default_nettype wire

// ===== bench/host_dma_model.sv
// host slave-dma model streaming a word pattern while armed
`timescale 1ns/1ps
`default_nettype none
module host_dma_model
    import disk_dma_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              armed,
    input  wire logic              slow,
    input  wire logic [WORD_W-1:0] base,
    input  wire logic              dmarq,
    output logic                   dma_wr,
    output logic      [WORD_W-1:0] dma_data
);
    logic [15:0]       idx_q;
    logic              go_q;
    logic [WORD_W-1:0] word;

    // word index and pacing; a slow host strobes every other cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idx_q <= 16'h0000;
            go_q  <= 1'b0;
        end
        else
        begin
            go_q <= slow ? ~go_q : 1'b1;
            if (!armed)
                idx_q <= 16'h0000; // channel set up before the command byte
            else if (dma_wr)
                idx_q <= idx_q + 16'h0001;
        end
    end

    // strobe only while the device requests; idle bus shows the inverse
    assign word     = base ^ (idx_q * 16'h9e37);
    assign dma_wr   = armed & dmarq & go_q;
    assign dma_data = dma_wr ? word : ~word;
endmodule // host_dma_model
`default_nettype wire

// ===== bench/tb_disk_dma_write.sv
// self-checking bench for the dma write command block
`timescale 1ns/1ps
`default_nettype none
module tb_disk_dma_write
    import disk_dma_pkg::*;
;
    logic              core_clk, rst_b, intrq_q, dmarq, dma_wr, med_valid, med_ready;
    logic              med_done, med_unc, armed, slow, intrq_d, fast_med;
    tf_req_t           tf_req;
    media_word_t       med_word;
    logic [7:0]        tf_rdata_q, buf_rd_addr, c;
    logic [WORD_W-1:0] dma_data, base, buf_rd_data_q;
    logic [31:0]       r;
    int                n_errors, tests_run, seed, cyc, widx, sec_idx, fail_at, irq_cnt, done_wait;

    disk_dma_write uut (.core_clk(core_clk), .rst_b(rst_b), .tf_req(tf_req),
        .tf_rdata_q(tf_rdata_q), .intrq_q(intrq_q), .dmarq(dmarq), .dma_wr(dma_wr),
        .dma_data(dma_data), .med_valid(med_valid), .med_ready(med_ready),
        .med_word(med_word), .med_done(med_done), .med_unc(med_unc),
        .buf_rd_addr(buf_rd_addr), .buf_rd_data_q(buf_rd_data_q));
    host_dma_model host (.core_clk(core_clk), .rst_b(rst_b), .armed(armed), .slow(slow),
        .base(base), .dmarq(dmarq), .dma_wr(dma_wr), .dma_data(dma_data));

    // clock generator
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] exp_word(input int n);
        return base ^ (16'(n) * 16'h9e37);
    endfunction

    // address of the k-th sector after a, in block or track geometry
    function automatic logic [27:0] step(input logic [27:0] a, input int k, input logic lba);
        logic [7:0]  s;
        logic [3:0]  h;
        logic [15:0] cy;
        if (lba)
            return a + 28'(k);
        {h, cy, s} = a;
        repeat (k)
        begin
            if (s == GEOM_SECTORS)
            begin
                s = 8'h01;
                cy = (h == GEOM_LAST_HEAD) ? cy + 16'h0001 : cy;
                h = h + 4'h1;
            end
            else
                s = s + 8'h01;
        end
        return {h, cy, s};
    endfunction

    task automatic tf_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        tf_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        tf_req <= '0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
        @(posedge core_clk);
        tf_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        tf_req <= '0;
        #1 chk({8'h00, tf_rdata_q & m}, {8'h00, e}, what);
    endtask

    // issue one command, wait for its interrupt and check ending state
    task automatic run_cmd(input logic [7:0] cmd, input logic [7:0] cnt, input logic [27:0] a,
                           input logic lba, input int fail, input logic slow_m);
        int         n;
        int         k;
        logic       med;
        logic       bufc;
        logic [27:0] e;
        n = (cnt == 8'h00) ? 256 : int'(cnt);
        med = (cmd[7:1] == CMD_MEDIA_WRITE_DMA[7:1]);
        bufc = (cmd == CMD_BUF_WRITE_DMA);
        fail_at = fail;
        widx = 0;
        sec_idx = 0;
        irq_cnt = 0;
        tf_wr(TF_COUNT, cnt);
        tf_wr(TF_SECTOR, a[7:0]);
        tf_wr(TF_CYL_LO, a[15:8]);
        tf_wr(TF_CYL_HI, a[23:16]);
        tf_wr(TF_DEV_HEAD, {1'b1, lba, 1'b1, 1'b0, a[27:24]});
        armed <= 1'b1;
        slow <= slow_m;
        base <= 16'($random(seed));
        tf_wr(TF_CMD_STAT, cmd);
        if (med || bufc)
            tf_wr(TF_COUNT, 8'h5a);
        for (k = 0; k < 80000 && intrq_q !== 1'b1; k++)
            @(posedge core_clk);
        armed <= 1'b0;
        chk({15'h0, intrq_q}, 16'h0001, "interrupt");
        k = (fail >= 0) ? fail : n - 1;
        e = step(a, med ? k : 0, lba);
        chk(16'(widx), med ? 16'((k + 1) * 256) : 16'h0000, "media words");
        rchk(TF_FEAT_ERR, 8'hff, !(med || bufc) ? 8'h04 : (fail >= 0 ? 8'h40 : 8'h00), "err");
        if (med || bufc)
        begin
            rchk(TF_COUNT, 8'hff, med ? 8'(n - k - 1 + (fail >= 0)) : cnt, "count");
            rchk(TF_SECTOR, 8'hff, e[7:0], "sector");
            rchk(TF_CYL_LO, 8'hff, e[15:8], "cyl lo");
            rchk(TF_CYL_HI, 8'hff, e[23:16], "cyl hi");
            rchk(TF_DEV_HEAD, 8'h0f, {4'h0, e[27:24]}, "head");
        end
        rchk(TF_CMD_STAT, 8'hff, (med || bufc) && fail < 0 ? 8'h50 : 8'h51, "status");
        repeat (3) @(negedge core_clk);
        chk({15'h0, intrq_q}, 16'h0000, "interrupt cleared");
        chk(16'(irq_cnt), 16'h0001, "one interrupt");
        for (k = 0; bufc && k < SECTOR_WORDS; k++)
        begin
            @(posedge core_clk);
            buf_rd_addr <= 8'(k);
            @(posedge core_clk);
            #1 chk(buf_rd_data_q, exp_word(k), "buffer word");
        end
    endtask

    // media side: random ready, word checks, sector done pulses
    always @(posedge core_clk)
    begin
        if (med_valid && med_ready)
        begin
            chk(med_word.data, exp_word(widx), "media data");
            chk({15'h0, med_word.last}, {15'h0, widx % 256 == 255}, "last");
            done_wait = (widx % 256 == 255) ? 3 : done_wait;
            widx++;
        end
        med_done <= (done_wait == 1);
        med_unc <= (done_wait == 1) && (sec_idx == fail_at);
        sec_idx = sec_idx + (done_wait == 1);
        done_wait = (done_wait > 0) ? done_wait - 1 : 0;
        med_ready <= fast_med | 1'($random(seed)); // long runs keep the media side ready
    end

    // interrupt edge counter and run ceiling
    always @(posedge core_clk)
    begin
        irq_cnt = irq_cnt + (intrq_q && !intrq_d);
        intrq_d <= intrq_q;
        cyc++;
        if (cyc == 100000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // main sequence
    initial
    begin
        seed = 40000;
        {n_errors, tests_run, cyc, widx, sec_idx, irq_cnt, done_wait} = '0;
        fail_at = -1;
        {rst_b, armed, slow, med_ready, med_done, med_unc, intrq_d, fast_med} = '0;
        tf_req = '0;
        base = 16'h0000;
        buf_rd_addr = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(TF_CMD_STAT, 8'hff, 8'h50, "reset status");
        rchk(TF_FEAT_ERR, 8'hff, ERR_RESET, "reset err");
        chk({14'h0, dmarq, med_valid}, 16'h0000, "reset idle");
        run_cmd(CMD_BUF_WRITE_DMA, 8'h07, 28'h1234567, 1'b1, -1, 1'b0);
        do
            c = 8'($random(seed));
        while (c == CMD_BUF_WRITE_DMA || c[7:1] == CMD_MEDIA_WRITE_DMA[7:1]);
        run_cmd(c, 8'h01, 28'h0000000, 1'b1, -1, 1'b0);
        run_cmd(CMD_MEDIA_WRITE_DMA, 8'h01, 28'h00abcde, 1'b1, -1, 1'b0);
        run_cmd(CMD_MEDIA_WRITE_DMA | 8'h01, 8'h02, 28'hf01023f, 1'b0, -1, 1'b1);
        run_cmd(CMD_MEDIA_WRITE_DMA, 8'h03, 28'h0ffffff, 1'b1, 1, 1'b0);
        repeat (2)
        begin
            r = $random(seed);
            run_cmd(CMD_MEDIA_WRITE_DMA | {7'h0, r[0]}, {6'h0, r[2:1]} + 8'h01, r[31:4],
                    1'b1, -1, r[3]);
        end
        fast_med = 1'b1;
        run_cmd(CMD_MEDIA_WRITE_DMA, 8'h00, 28'h0000100, 1'b1, -1, 1'b0);
        stop_test();
    end
endmodule // tb_disk_dma_write
`default_nettype wire
